// >>> rtl/bteg_consts.vh
// constants of the buzzer tone and envelope generator
`ifndef BTEG_CONSTS_VH
`define BTEG_CONSTS_VH

// ----------------------------------------------------------------
// register port
// ----------------------------------------------------------------
`define BTEG_ADDR_W 4
`define BTEG_DATA_W 4
`define BTEG_ADDR_CTRL 4'h0
`define BTEG_ADDR_FREQ 4'h1
`define BTEG_ADDR_LEVEL 4'h2
`define BTEG_ADDR_STAT 4'h3
`define BTEG_DATA_ZERO 4'h0

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define BTEG_CTRL_EN 0
`define BTEG_CTRL_ENV_ON 1
`define BTEG_CTRL_RESTART 2
`define BTEG_CTRL_STEP_TIME 3

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define BTEG_STAT_LVL_LSB 0
`define BTEG_STAT_LVL_MSB 2
`define BTEG_STAT_PIN 3

// ----------------------------------------------------------------
// select fields and reset values
// ----------------------------------------------------------------
`define BTEG_SEL_W 3
`define BTEG_SEL_RST 3'h0
`define BTEG_BIT_RST 1'b0
`define BTEG_LVL_MAX 3'h0
`define BTEG_LVL_MIN 3'h7
`define BTEG_LVL_INC 3'h1
`define BTEG_SEL_OCT 2
`define BTEG_SEL_IDX_MSB 1

// ----------------------------------------------------------------
// tone period and high time, in half cycles of the slow oscillator
// ----------------------------------------------------------------
`define BTEG_CNT_W 6
`define BTEG_CNT_ZERO 6'h00
`define BTEG_CNT_INC 6'h01
`define BTEG_PER0 6'h10
`define BTEG_PER1 6'h14
`define BTEG_PER2 6'h18
`define BTEG_PER3 6'h1C
`define BTEG_TOP0 6'h08
`define BTEG_TOP1 6'h08
`define BTEG_TOP2 6'h0C
`define BTEG_TOP3 6'h0C

// ----------------------------------------------------------------
// envelope step timing
// ----------------------------------------------------------------
`define BTEG_OSC_HZ 32768
`define BTEG_STEP_SHORT_US 62500
`define BTEG_STEP_LONG_US 125000
`define BTEG_STEP_SHORT_TICKS (`BTEG_STEP_SHORT_US * (`BTEG_OSC_HZ / 64) / 15625)
`define BTEG_STEP_LONG_TICKS (`BTEG_STEP_LONG_US * (`BTEG_OSC_HZ / 64) / 15625)
`define BTEG_DIV_W 12

`endif

// >>> rtl/bteg_tone.v
// free-running tone period counter and duty compare
`timescale 1ns/10ps
`include "bteg_consts.vh"

module bteg_tone #(
	parameter CNT_W = `BTEG_CNT_W
) (
	input wire ref_clk_in,
	input wire resetn_in,
	input wire half_tick_in,
	input wire [`BTEG_SEL_W-1:0] tone_frequency_select_in,
	input wire [`BTEG_SEL_W-1:0] level_in,
	output reg tone_high_out
);

// ----------------------------------------------------------------
// decoding of the frequency code
// ----------------------------------------------------------------
function [CNT_W-1:0] period_of;
	input [`BTEG_SEL_W-1:0] sel;
	reg [CNT_W-1:0] base;
	begin
		case (sel[`BTEG_SEL_IDX_MSB:0])
			2'h0: base = `BTEG_PER0;
			2'h1: base = `BTEG_PER1;
			2'h2: base = `BTEG_PER2;
			default: base = `BTEG_PER3;
		endcase
		// lower octave doubles the period
		period_of = sel[`BTEG_SEL_OCT] ? {base[CNT_W-2:0], 1'b0} : base;
	end
endfunction

function [CNT_W-1:0] high_of;
	input [`BTEG_SEL_W-1:0] sel;
	input [`BTEG_SEL_W-1:0] lvl;
	reg [CNT_W-1:0] top;
	reg [CNT_W-1:0] hi;
	begin
		case (sel[`BTEG_SEL_IDX_MSB:0])
			2'h0: top = `BTEG_TOP0;
			2'h1: top = `BTEG_TOP1;
			2'h2: top = `BTEG_TOP2;
			default: top = `BTEG_TOP3;
		endcase
		hi = top - {{(CNT_W-`BTEG_SEL_W){1'b0}}, lvl};
		high_of = sel[`BTEG_SEL_OCT] ? {hi[CNT_W-2:0], 1'b0} : hi;
	end
endfunction

// ----------------------------------------------------------------
// counter and compare
// ----------------------------------------------------------------
reg [CNT_W-1:0] cnt_r;
reg [CNT_W-1:0] cnt_nxt;
wire [CNT_W-1:0] period_last;

assign period_last = period_of(tone_frequency_select_in) - `BTEG_CNT_INC;

always @* begin
	cnt_nxt = cnt_r;
	if (half_tick_in) begin
		// >= recovers at once when a shorter period is selected
		if (cnt_r >= period_last) begin
			cnt_nxt = `BTEG_CNT_ZERO;
		end else begin
			cnt_nxt = cnt_r + `BTEG_CNT_INC;
		end
	end
end

always @(posedge ref_clk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		cnt_r <= `BTEG_CNT_ZERO;
		tone_high_out <= `BTEG_BIT_RST;
	end else begin
		cnt_r <= cnt_nxt;
		tone_high_out <= (cnt_r < high_of(tone_frequency_select_in, level_in));
	end
end

endmodule

// >>> rtl/bteg_top.v
// buzzer tone and envelope generator top with register port
`timescale 1ns/10ps
`include "bteg_consts.vh"

module bteg_top #(
	parameter DIV_W = `BTEG_DIV_W
) (
	input wire ref_clk_in,
	input wire resetn_in,
	input wire low_speed_oscillator_in,
	input wire [`BTEG_ADDR_W-1:0] addr_in,
	input wire [`BTEG_DATA_W-1:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [`BTEG_DATA_W-1:0] rdata_out,
	output reg tone_output_pin_out
);

// ----------------------------------------------------------------
// constants
// ----------------------------------------------------------------
// step lengths in slow oscillator periods, cut to the divider width
localparam integer SHORT_TICKS = `BTEG_STEP_SHORT_TICKS;
localparam integer LONG_TICKS = `BTEG_STEP_LONG_TICKS;
localparam integer SHORT_END = SHORT_TICKS - 1;
localparam integer LONG_END = LONG_TICKS - 1;
localparam [DIV_W-1:0] DIV_ZERO = {DIV_W{1'b0}};
localparam [DIV_W-1:0] DIV_INC = {{(DIV_W-1){1'b0}}, 1'b1};
localparam [DIV_W-1:0] SHORT_LAST = SHORT_END[DIV_W-1:0];
localparam [DIV_W-1:0] LONG_LAST = LONG_END[DIV_W-1:0];

// envelope states, one-hot
localparam [2:0] ST_IDLE = 3'h1;
localparam [2:0] ST_DECAY = 3'h2;
localparam [2:0] ST_HOLD = 3'h4;

// ----------------------------------------------------------------
// address decode
// ----------------------------------------------------------------
function hit;
	input [`BTEG_ADDR_W-1:0] addr;
	input [`BTEG_ADDR_W-1:0] target;
	begin
		hit = (addr == target);
	end
endfunction

// unmapped addresses fall through: writes are dropped, reads give zero
wire wr_ctrl;
wire wr_freq;
wire wr_level;

assign wr_ctrl = wr_in & hit(addr_in, `BTEG_ADDR_CTRL);
assign wr_freq = wr_in & hit(addr_in, `BTEG_ADDR_FREQ);
assign wr_level = wr_in & hit(addr_in, `BTEG_ADDR_LEVEL);

// ----------------------------------------------------------------
// control registers
// ----------------------------------------------------------------
reg tone_output_enable_r;
reg envelope_on_r;
reg envelope_step_time_r;
reg [`BTEG_SEL_W-1:0] tone_frequency_select_r;
reg [`BTEG_SEL_W-1:0] level_duty_select_r;
wire envelope_restart;

// restart has no storage: it is a pulse of the write
assign envelope_restart = wr_ctrl & wdata_in[`BTEG_CTRL_RESTART];

always @(posedge ref_clk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		tone_output_enable_r <= `BTEG_BIT_RST;
		envelope_on_r <= `BTEG_BIT_RST;
		envelope_step_time_r <= `BTEG_BIT_RST;
		tone_frequency_select_r <= `BTEG_SEL_RST;
		level_duty_select_r <= `BTEG_SEL_RST;
	end else begin
		if (wr_ctrl) begin
			tone_output_enable_r <= wdata_in[`BTEG_CTRL_EN];
			envelope_on_r <= wdata_in[`BTEG_CTRL_ENV_ON];
			envelope_step_time_r <= wdata_in[`BTEG_CTRL_STEP_TIME];
		end
		if (wr_freq) begin
			tone_frequency_select_r <= wdata_in[`BTEG_SEL_W-1:0];
		end
		if (wr_level) begin
			level_duty_select_r <= wdata_in[`BTEG_SEL_W-1:0];
		end
	end
end

// ----------------------------------------------------------------
// slow oscillator edges
// ----------------------------------------------------------------
reg osc_d_r;
wire half_tick;
wire full_tick;

// both edges give half-period resolution for the duty compare
assign half_tick = low_speed_oscillator_in ^ osc_d_r;
assign full_tick = low_speed_oscillator_in & ~osc_d_r;

always @(posedge ref_clk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		osc_d_r <= `BTEG_BIT_RST;
	end else begin
		osc_d_r <= low_speed_oscillator_in;
	end
end

// ----------------------------------------------------------------
// free-running envelope divider
// ----------------------------------------------------------------
reg [DIV_W-1:0] div_r;
reg [DIV_W-1:0] div_nxt;
reg step_tick;

always @* begin
	div_nxt = div_r;
	step_tick = 1'b0;
	if (full_tick) begin
		if (div_r == LONG_LAST) begin
			div_nxt = DIV_ZERO;
		end else begin
			div_nxt = div_r + DIV_INC;
		end
		// never restarted, so the first step may come early
		if (envelope_step_time_r) begin
			step_tick = (div_r == LONG_LAST);
		end else begin
			step_tick = (div_r == SHORT_LAST) | (div_r == LONG_LAST);
		end
	end
end

always @(posedge ref_clk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		div_r <= DIV_ZERO;
	end else begin
		div_r <= div_nxt;
	end
end

// ----------------------------------------------------------------
// envelope stepping
// ----------------------------------------------------------------
reg [2:0] env_state_r;
reg [2:0] env_state_nxt;
reg [`BTEG_SEL_W-1:0] env_level_r;
reg [`BTEG_SEL_W-1:0] env_level_nxt;
wire env_run;

// level code counts up as the duty falls; restart wins over a step
assign env_run = tone_output_enable_r & envelope_on_r;

always @* begin
	env_state_nxt = env_state_r;
	env_level_nxt = env_level_r;
	case (env_state_r)
		ST_IDLE: begin
			env_level_nxt = `BTEG_LVL_MAX;
			if (env_run) begin
				env_state_nxt = ST_DECAY;
			end
		end
		ST_DECAY: begin
			if (!env_run) begin
				env_state_nxt = ST_IDLE;
				env_level_nxt = `BTEG_LVL_MAX;
			end else if (envelope_restart) begin
				env_level_nxt = `BTEG_LVL_MAX;
			end else if (step_tick) begin
				env_level_nxt = env_level_r + `BTEG_LVL_INC;
				if (env_level_nxt == `BTEG_LVL_MIN) begin
					env_state_nxt = ST_HOLD;
				end
			end
		end
		ST_HOLD: begin
			if (!env_run) begin
				env_state_nxt = ST_IDLE;
				env_level_nxt = `BTEG_LVL_MAX;
			end else if (envelope_restart) begin
				env_state_nxt = ST_DECAY;
				env_level_nxt = `BTEG_LVL_MAX;
			end else begin
				env_level_nxt = `BTEG_LVL_MIN;
			end
		end
		default: begin
			env_state_nxt = ST_IDLE;
			env_level_nxt = `BTEG_LVL_MAX;
		end
	endcase
end

always @(posedge ref_clk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		env_state_r <= ST_IDLE;
		env_level_r <= `BTEG_LVL_MAX;
	end else begin
		env_state_r <= env_state_nxt;
		env_level_r <= env_level_nxt;
	end
end

// ----------------------------------------------------------------
// tone waveform
// ----------------------------------------------------------------
wire [`BTEG_SEL_W-1:0] level_used;
wire tone_high;

// higher code means shorter high time in every column
assign level_used = envelope_on_r ? env_level_r : level_duty_select_r;

bteg_tone #(
	.CNT_W(`BTEG_CNT_W)
) u_tone (
	.ref_clk_in(ref_clk_in),
	.resetn_in(resetn_in),
	.half_tick_in(half_tick),
	.tone_frequency_select_in(tone_frequency_select_r),
	.level_in(level_used),
	.tone_high_out(tone_high)
);

// ----------------------------------------------------------------
// output pin
// ----------------------------------------------------------------
// the tone is gated as it runs, so a switch may cut a pulse short
always @(posedge ref_clk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		tone_output_pin_out <= `BTEG_BIT_RST;
	end else if (tone_output_enable_r) begin
		tone_output_pin_out <= tone_high;
	end else begin
		tone_output_pin_out <= 1'b0;
	end
end

// ----------------------------------------------------------------
// read back
// ----------------------------------------------------------------
// read data stand for the one cycle after the strobe, zero otherwise
reg [`BTEG_DATA_W-1:0] rdata_nxt;

always @* begin
	rdata_nxt = `BTEG_DATA_ZERO;
	if (rd_in) begin
		case (addr_in)
			`BTEG_ADDR_CTRL: begin
				rdata_nxt[`BTEG_CTRL_EN] = tone_output_enable_r;
				rdata_nxt[`BTEG_CTRL_ENV_ON] = envelope_on_r;
				rdata_nxt[`BTEG_CTRL_RESTART] = 1'b0;
				rdata_nxt[`BTEG_CTRL_STEP_TIME] = envelope_step_time_r;
			end
			`BTEG_ADDR_FREQ: begin
				rdata_nxt[`BTEG_SEL_W-1:0] = tone_frequency_select_r;
			end
			`BTEG_ADDR_LEVEL: begin
				rdata_nxt[`BTEG_SEL_W-1:0] = level_duty_select_r;
			end
			`BTEG_ADDR_STAT: begin
				rdata_nxt[`BTEG_STAT_LVL_MSB:`BTEG_STAT_LVL_LSB] = env_level_r;
				rdata_nxt[`BTEG_STAT_PIN] = tone_output_pin_out;
			end
			default: begin
				rdata_nxt = `BTEG_DATA_ZERO;
			end
		endcase
	end
end

always @(posedge ref_clk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		rdata_out <= `BTEG_DATA_ZERO;
	end else begin
		rdata_out <= rdata_nxt;
	end
end

endmodule

// >>> sim/bteg_buzz_model.sv
// buzzer load model that measures high and low run lengths on the pin
`timescale 1ns/10ps
module bteg_buzz (
	input wire ref_clk_in,
	input wire pin_in,
	output reg [7:0] hi_out,
	output reg [7:0] lo_out
);
	reg [7:0] n_r = 8'h00;
	reg p_r = 1'b0;
	initial begin
		hi_out = 8'h00;
		lo_out = 8'h00;
	end
	// run length in clocks, stored when the level flips
	always @(posedge ref_clk_in) begin
		p_r <= pin_in;
		if (pin_in != p_r) begin
			n_r <= 8'h01;
			if (p_r) begin
				hi_out <= n_r;
			end else begin
				lo_out <= n_r;
			end
		end else begin
			n_r <= n_r + 8'h01;
		end
	end
endmodule

// >>> sim/bteg_top_properties.sv
// port checker of the buzzer tone and envelope generator
`timescale 1ns/10ps
module bteg_chk #(parameter DIV_W = 12) (
	input wire ref_clk_in,
	input wire resetn_in,
	input wire low_speed_oscillator_in,
	input wire [3:0] addr_in,
	input wire [3:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	input wire [3:0] rdata_out,
	input wire tone_output_pin_out
);
	reg [3:0] ctl_r;
	reg [2:0] frq_r;
	reg [2:0] lvl_r;
	reg [7:0] qt_r;
	reg [7:0] hi_r;
	reg [7:0] lo_r;
	reg [1:0] off_r;
	reg osc_r;
	wire chg = low_speed_oscillator_in != osc_r;
	wire pin = tone_output_pin_out;
	wire [5:0] top = frq_r[1] ? 6'h0C : 6'h08;
	wire [5:0] hi = (top - {3'h0, lvl_r}) << frq_r[2];
	wire [5:0] pd = (6'h10 + {2'h0, frq_r[1:0], 2'h0}) << frq_r[2];
	// ----------------------------------------------------------------
	// shadow of the control fields and pulse length counters
	// ----------------------------------------------------------------
	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctl_r <= 4'h0;
			frq_r <= 3'h0;
			lvl_r <= 3'h0;
			qt_r <= 8'h00;
			hi_r <= 8'h00;
			lo_r <= 8'h00;
			off_r <= 2'h0;
			osc_r <= 1'b0;
		end else begin
			osc_r <= low_speed_oscillator_in;
			if (wr_in && addr_in == 4'h0) ctl_r <= {wdata_in[3], 1'b0, wdata_in[1:0]};
			if (wr_in && addr_in == 4'h1) frq_r <= wdata_in[2:0];
			if (wr_in && addr_in == 4'h2) lvl_r <= wdata_in[2:0];
			qt_r <= wr_in ? 8'h00 : (qt_r == 8'hFF ? qt_r : qt_r + 8'h01);
			hi_r <= pin ? hi_r + {7'h00, chg} : 8'h00;
			lo_r <= pin ? 8'h00 : lo_r + {7'h00, chg};
			off_r <= ctl_r[0] ? 2'h0 : (off_r == 2'h3 ? off_r : off_r + 2'h1);
		end
	end
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_ctl_rd; rd_in && addr_in == 4'h0 |=> rdata_out == $past(ctl_r); endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
	property p_frq_rd; rd_in && addr_in == 4'h1 |=> rdata_out == {1'b0, $past(frq_r)}; endproperty
	a_frq_rd: assert property (p_frq_rd) else $error("tone code readback wrong");
	property p_lvl_rd; rd_in && addr_in == 4'h2 |=> rdata_out == {1'b0, $past(lvl_r)}; endproperty
	a_lvl_rd: assert property (p_lvl_rd) else $error("level code readback wrong");
	property p_pin_off; off_r == 2'h3 |-> !pin; endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin not low while off");
	property p_pin_runs; $fell(pin) && ctl_r[0] |-> ##[1:120] (pin || !ctl_r[0]); endproperty
	a_pin_runs: assert property (p_pin_runs) else $error("tone stalled while on");
	property p_hi_time; $fell(pin) && qt_r == 8'hFF && !ctl_r[1] |-> hi_r == {2'h0, hi}; endproperty
	a_hi_time: assert property (p_hi_time) else $error("high time wrong");
	property p_lo_time; $rose(pin) && qt_r == 8'hFF && !ctl_r[1] |-> lo_r == {2'h0, pd - hi}; endproperty
	a_lo_time: assert property (p_lo_time) else $error("low time wrong");
	property p_restart;
		wr_in && addr_in == 4'h0 && wdata_in[2:0] == 3'h7 ##2 rd_in && addr_in == 4'h3
		|=> rdata_out[2:0] < 3'h2;
	endproperty
	a_restart: assert property (p_restart) else $error("restart left level high");
	property p_env_idle;
		rd_in && addr_in == 4'h3 && !(ctl_r[0] && ctl_r[1]) && !($past(ctl_r[0]) && $past(ctl_r[1]))
		|=> rdata_out[2:0] == 3'h0;
	endproperty
	a_env_idle: assert property (p_env_idle) else $error("envelope level not idle");
	c_restart: cover property (wr_in && addr_in == 4'h0 && wdata_in[2]);
	c_pulse: cover property ($fell(pin) && qt_r == 8'hFF);
	c_off: cover property (off_r == 2'h3 && rd_in);
endmodule
bind bteg_top bteg_chk #(.DIV_W(DIV_W)) chk_u (
	.ref_clk_in(ref_clk_in),
	.resetn_in(resetn_in),
	.low_speed_oscillator_in(low_speed_oscillator_in),
	.addr_in(addr_in),
	.wdata_in(wdata_in),
	.wr_in(wr_in),
	.rd_in(rd_in),
	.rdata_out(rdata_out),
	.tone_output_pin_out(tone_output_pin_out)
);

// >>> sim/buzzer_tone_envelope_generator_tb.sv
// testbench of the buzzer tone and envelope generator
`timescale 1ns/10ps
module buzzer_tone_envelope_generator_tb;
	reg clk = 1'b0;
	reg rstn = 1'b0;
	reg osc = 1'b0;
	reg [3:0] addr = 4'h0;
	reg [3:0] wdata = 4'h0;
	reg wr = 1'b0;
	reg rd = 1'b0;
	wire [3:0] rdata;
	wire pin;
	wire [7:0] hi;
	wire [7:0] lo;
	integer n_fail = 0;
	integer checked = 0;
	integer i;
	time t0;
	reg [3:0] d;
	reg [7:0] eh;
	reg [7:0] ep;
	always #20 clk = ~clk;
	// slow oscillator sped up to one half tick per clock
	always @(posedge clk) osc <= ~osc;
	bteg_top dut_u (.ref_clk_in(clk), .resetn_in(rstn), .low_speed_oscillator_in(osc),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.tone_output_pin_out(pin));
	bteg_buzz buzz_u (.ref_clk_in(clk), .pin_in(pin), .hi_out(hi), .lo_out(lo));
	task chk(input [7:0] seen, input [7:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task wr_reg(input [3:0] a, input [3:0] v);
		begin
			@(posedge clk);
			wr <= 1'b1;
			addr <= a;
			wdata <= v;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task rd_reg(input [3:0] a);
		begin
			@(posedge clk);
			rd <= 1'b1;
			addr <= a;
			@(posedge clk);
			rd <= 1'b0;
			#1;
			d = rdata;
		end
	endtask
	// poll the envelope level until it reaches v
	task wait_lvl(input [2:0] v);
		integer k;
		begin
			k = 0;
			rd_reg(4'h3);
			while (d[2:0] !== v && k < 12000) begin
				rd_reg(4'h3);
				k = k + 1;
			end
			chk(d[2:0], v);
		end
	endtask
	task step_gap(input integer n);
		begin
			wait_lvl(3'h1);
			t0 = $time;
			wait_lvl(3'h2);
			chk(($time - t0) / 40 >= n - 2 && ($time - t0) / 40 <= n + 2, 8'h01);
		end
	endtask
	task final_report;
		begin
			$display("checks %0d mismatches %0d", checked, n_fail);
			if (n_fail == 0 && checked > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	initial begin
		#4000000;
		n_fail = n_fail + 1;
		final_report;
	end
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		wr_reg(4'h9, 4'hF);
		for (i = 0; i < 4; i = i + 1) begin
			rd_reg(i[3:0]);
			chk(d, 4'h0);
		end
		rd_reg(4'h9);
		chk(d, 4'h0);
		repeat (100) begin
			@(posedge clk);
			#1;
			chk(pin, 1'b0);
		end
		$display("test reset done");
		wr_reg(4'h0, 4'h1);
		for (i = 0; i < 16; i = i + 1) begin
			wr_reg(4'h1, {1'b0, i[3:1]});
			wr_reg(4'h2, {1'b0, i[2:0]});
			// long enough for the checker's settle counter to saturate
			repeat (320) @(posedge clk);
			#1;
			ep = (8'h10 + {4'h0, i[2:1], 2'h0}) << i[3];
			eh = ((i[2] ? 8'h0C : 8'h08) - {5'h00, i[2:0]}) << i[3];
			chk(hi, eh);
			chk(hi + lo, ep);
		end
		$display("test tones done");
		wr_reg(4'h1, 4'h0);
		wr_reg(4'h2, 4'h5);
		wr_reg(4'h0, 4'h3);
		rd_reg(4'h3);
		chk(d[2:0], 3'h0);
		step_gap(4096);
		wait_lvl(3'h7);
		repeat (5000) @(posedge clk);
		rd_reg(4'h3);
		chk(d[2:0], 3'h7);
		chk(hi, 8'h01);
		wr_reg(4'h0, 4'h7);
		rd_reg(4'h3);
		chk(d[2:0], 3'h0);
		rd_reg(4'h0);
		chk(d, 4'h3);
		$display("test envelope done");
		wr_reg(4'h0, 4'h9);
		wr_reg(4'h0, 4'hB);
		step_gap(8192);
		wr_reg(4'h0, 4'h1);
		repeat (200) @(posedge clk);
		#1;
		chk(hi, 8'h03);
		$display("test long step done");
		wr_reg(4'h0, 4'h0);
		repeat (4) @(posedge clk);
		#1;
		chk(pin, 1'b0);
		$display("test disable done");
		final_report;
	end
endmodule
